// file: hdl/ptimer_pkg.sv
/*
 * Constants for one pair of 8-bit programmable down-counter timers:
 * register indices, field positions, reset values, filter width and
 * prescaler ratios. Assumes AXI4-Lite with 32-bit data, byte address
 * equal to four times the register index.
 */
// How it works
// - a pair holds a 16-bit presettable down counter, split as two 8-bit timers
// - each 8-bit counter has its own reload register and compare register
// - bit 7 of the first control register picks 8-bit pair or 16-bit; resets 0
// - in 8-bit mode each timer obeys its own control bits, except the low one's filter enable b6, which serves both
// - in 16-bit mode low timer underflow clocks the high timer
// - 16-bit mode uses low run, preset, clock select; high ones read 0
// - control bits: output enable b3, run b2, preset b1 reads 0, select b0
// - clock select 0 takes the prescaler, 1 takes the shared external input
// - optional filter drops external pulses under 16 slow oscillator periods
// - source select 1 feeds the prescaler from slow, 0 from fast oscillator
// - 3-bit ratio: fast 1..4096, slow 1..128 in the listed steps
// - the prescaled clock reaches a timer only while its gate bit is 1
// - in 16-bit mode the high timer's clock settings are ignored
// - timer underflows are provided as outputs for serial and display use
// - reload and compare together form a PWM output waveform
// - run 1 counts down, run 0 blocks the clock and holds the count
// - underflow reloads; preset loads at once, 16 bits via the low preset
// - reset sets reload registers to FF and compare registers to 00
package ptimer_pkg;

	localparam int ADDR_W = 18;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_CTRL_L  = 16'hFF30;
	localparam logic [15:0] IDX_CTRL_H  = 16'hFF31;
	localparam logic [15:0] IDX_RELOAD_L = 16'hFF32;
	localparam logic [15:0] IDX_RELOAD_H = 16'hFF33;
	localparam logic [15:0] IDX_CMP_L   = 16'hFF34;
	localparam logic [15:0] IDX_CMP_H   = 16'hFF35;
	localparam logic [15:0] IDX_PRESC_L = 16'hFF36;
	localparam logic [15:0] IDX_PRESC_H = 16'hFF37;
	localparam logic [15:0] IDX_COUNT_L = 16'hFF38;
	localparam logic [15:0] IDX_COUNT_H = 16'hFF39;

	// control register fields
	localparam int B_MODE   = 7;
	localparam int B_FLT    = 6;
	localparam int B_RSV    = 4;
	localparam int B_OE     = 3;
	localparam int B_RUN    = 2;
	localparam int B_PRESET = 1;
	localparam int B_CKSEL  = 0;

	// prescaler register fields
	localparam int B_GATE  = 4;
	localparam int B_SRC   = 3;
	localparam int B_RATIO = 0;

	localparam logic [7:0] RELOAD_RST = 8'hFF;
	localparam logic [7:0] CMP_RST    = 8'h00;
	localparam logic [7:0] CNT_RST    = 8'hFF;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// filter width in slow oscillator periods
	localparam int         FLT_PERIODS = 16;
	localparam logic [3:0] FLT_LAST    = 4'(FLT_PERIODS - 1);

	// division ratio minus one for a source and ratio code
	function automatic logic [11:0] presc_div_m1(input logic       slow,
	                                             input logic [2:0] code);
		logic [11:0] r;
		r = 12'h000;
		if (slow) begin
			r = 12'((12'h001 << code) - 12'h001);
		end else begin
			unique case (code)
				3'h0: r = 12'h000;
				3'h1: r = 12'h001;
				3'h2: r = 12'h007;
				3'h3: r = 12'h01F;
				3'h4: r = 12'h03F;
				3'h5: r = 12'h0FF;
				3'h6: r = 12'h3FF;
				3'h7: r = 12'hFFF;
			endcase
		end
		return r;
	endfunction

endpackage

// file: hdl/timer_ch_if.sv
/*
 * Link between the pair controller and one 8-bit down counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface timer_ch_if;
	logic       tick;
	logic       preset;
	logic [7:0] reload;
	logic [7:0] compare;
	logic [7:0] count;
	logic       uf;
	logic       match;

	modport ctl (output tick, preset, reload, compare,
	             input  count, uf, match);
	modport chan (input  tick, preset, reload, compare,
	              output count, uf, match);
endinterface

// file: hdl/down_counter8.sv
/*
 * One 8-bit presettable down counter with reload and compare.
 * Assumes tick and preset are single-cycle strobes in the aclk domain.
 */
`timescale 1ns/1ps
module down_counter8
	import ptimer_pkg::*;
(
	input wire logic  aclk,
	input wire logic  aresetn,
	timer_ch_if.chan  ch
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	// ==========================================================
	// counting
	assign ch.count = cnt_q;
	assign ch.match = (cnt_q == ch.compare);
	assign ch.uf    = ch.tick && !ch.preset && (cnt_q == 8'h00);
	assign cnt_d    = ch.preset ? ch.reload :
	                  ch.uf     ? ch.reload :
	                  ch.tick   ? 8'(cnt_q - 8'h01) : cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= CNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_count_step: assert property (
		ch.tick && !ch.preset && ch.count != 8'h00
		|=> ch.count == 8'($past(ch.count) - 8'h01))
		else $error("count did not step down by one");

	a_reload_uf: assert property (
		ch.tick && !ch.preset && ch.count == 8'h00
		|-> ch.uf ##1 ch.count == $past(ch.reload))
		else $error("underflow did not reload");

	a_preset_load: assert property (
		ch.preset |=> ch.count == $past(ch.reload))
		else $error("preset did not load reload value");

endmodule

// file: hdl/timer_pair.sv
/*
 * Pair of 8-bit programmable timers, cascadable to 16 bits, with
 * prescaler, external event input, noise filter and PWM outputs,
 * behind an AXI4-Lite slave. Assumes slow_osc_tick and fast_osc_tick
 * are one-cycle strobes in the aclk domain, one per oscillator period.
 */
`timescale 1ns/1ps
module timer_pair
	import ptimer_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              slow_osc_tick,
	input  wire logic              fast_osc_tick,
	input  wire logic              external_count_clock,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [1:0]             timer_output_signal,
	output logic [1:0]             timer_underflow
);

	function automatic logic is_mapped(input logic [15:0] idx);
		return idx >= IDX_CTRL_L && idx <= IDX_COUNT_H;
	endfunction

	// ==========================================================
	// state
	logic        mode_q;
	logic        flt_en_q;
	logic [1:0]  rsv_q;
	logic [1:0]  oe_q;
	logic [1:0]  run_q;
	logic [1:0]  cksel_q;
	logic [1:0]  src_q;
	logic [1:0]  gate_q;
	logic [2:0]  ratio_q [2];
	logic [7:0]  rl_q [2];
	logic [7:0]  cmp_q [2];
	logic        preset_l_q;
	logic        preset_h_q;
	logic        ext_s1_q;
	logic        ext_s2_q;
	logic        flt_q;
	logic [3:0]  flt_cnt_q;
	logic        ext_prev_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [15:0] aw_idx_q;
	logic [7:0]  wd_q;
	logic        wstb_q;

	timer_ch_if ch_l ();
	timer_ch_if ch_h ();

	down_counter8 u_low (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ch      (ch_l.chan)
	);

	down_counter8 u_high (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ch      (ch_h.chan)
	);

	// ==========================================================
	// bus decode
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        do_wr;
	logic        aw_have_d;
	logic        w_have_d;
	logic        rvalid_d;
	logic        we_ctl_l;
	logic        we_ctl_h;
	logic [1:0]  we_rl;
	logic [1:0]  we_cmp;
	logic [1:0]  we_ps;
	logic [15:0] ar_idx;
	logic [7:0]  ctl_l_rd;
	logic [7:0]  ctl_h_rd;
	logic [7:0]  rd_byte;

	assign aw_take   = awvalid && awready;
	assign w_take    = wvalid && wready;
	assign ar_take   = arvalid && arready;
	assign do_wr     = aw_have_q && w_have_q && !bvalid;
	assign aw_have_d = aw_take ? 1'b1 : do_wr ? 1'b0 : aw_have_q;
	assign w_have_d  = w_take ? 1'b1 : do_wr ? 1'b0 : w_have_q;
	assign rvalid_d  = ar_take ? 1'b1 : rready ? 1'b0 : rvalid;

	assign we_ctl_l  = do_wr && wstb_q && aw_idx_q == IDX_CTRL_L;
	assign we_ctl_h  = do_wr && wstb_q && aw_idx_q == IDX_CTRL_H;
	assign we_rl[0]  = do_wr && wstb_q && aw_idx_q == IDX_RELOAD_L;
	assign we_rl[1]  = do_wr && wstb_q && aw_idx_q == IDX_RELOAD_H;
	assign we_cmp[0] = do_wr && wstb_q && aw_idx_q == IDX_CMP_L;
	assign we_cmp[1] = do_wr && wstb_q && aw_idx_q == IDX_CMP_H;
	assign we_ps[0]  = do_wr && wstb_q && aw_idx_q == IDX_PRESC_L;
	assign we_ps[1]  = do_wr && wstb_q && aw_idx_q == IDX_PRESC_H;

	// preset reads 0; in 16-bit mode the shadowed bits read 0
	assign ctl_l_rd = {mode_q, flt_en_q, 1'b0, rsv_q[0] && !mode_q,
	                   oe_q[0] && !mode_q, run_q[0], 1'b0, cksel_q[0]};
	assign ctl_h_rd = {3'h0, rsv_q[1], oe_q[1], run_q[1] && !mode_q,
	                   1'b0, cksel_q[1] && !mode_q};

	assign ar_idx  = araddr[17:2];
	assign rd_byte =
		ar_idx == IDX_CTRL_L   ? ctl_l_rd :
		ar_idx == IDX_CTRL_H   ? ctl_h_rd :
		ar_idx == IDX_RELOAD_L ? rl_q[0] :
		ar_idx == IDX_RELOAD_H ? rl_q[1] :
		ar_idx == IDX_CMP_L    ? cmp_q[0] :
		ar_idx == IDX_CMP_H    ? cmp_q[1] :
		ar_idx == IDX_PRESC_L  ? {3'h0, gate_q[0], src_q[0], ratio_q[0]} :
		ar_idx == IDX_PRESC_H  ? {3'h0, gate_q[1], src_q[1], ratio_q[1]} :
		ar_idx == IDX_COUNT_L  ? ch_l.count :
		ar_idx == IDX_COUNT_H  ? ch_h.count : 8'h00;

	// ==========================================================
	// bus handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			arready   <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			rvalid    <= 1'b0;
			rresp     <= RESP_OKAY;
			rdata     <= 32'h0000_0000;
			aw_idx_q  <= 16'h0000;
			wd_q      <= 8'h00;
			wstb_q    <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready   <= !aw_have_d;
			wready    <= !w_have_d;
			arready   <= !rvalid_d;
			rvalid    <= rvalid_d;
			if (aw_take) begin
				aw_idx_q <= awaddr[17:2];
			end
			if (w_take) begin
				wd_q   <= wdata[7:0];
				wstb_q <= wstrb[0];
			end
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp  <= is_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (ar_take) begin
				rdata <= {24'h00_0000, rd_byte};
				rresp <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q     <= 1'b0;
			flt_en_q   <= 1'b0;
			rsv_q      <= 2'h0;
			oe_q       <= 2'h0;
			run_q      <= 2'h0;
			cksel_q    <= 2'h0;
			src_q      <= 2'h0;
			gate_q     <= 2'h0;
			preset_l_q <= 1'b0;
			preset_h_q <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				ratio_q[i] <= 3'h0;
				rl_q[i]    <= RELOAD_RST;
				cmp_q[i]   <= CMP_RST;
			end
		end else begin
			preset_l_q <= we_ctl_l && wd_q[B_PRESET];
			preset_h_q <= we_ctl_h && wd_q[B_PRESET] && !mode_q;
			if (we_ctl_l) begin
				mode_q     <= wd_q[B_MODE];
				flt_en_q   <= wd_q[B_FLT];
				rsv_q[0]   <= wd_q[B_RSV];
				oe_q[0]    <= wd_q[B_OE];
				run_q[0]   <= wd_q[B_RUN];
				cksel_q[0] <= wd_q[B_CKSEL];
			end
			if (we_ctl_h) begin
				rsv_q[1]   <= wd_q[B_RSV];
				oe_q[1]    <= wd_q[B_OE];
				run_q[1]   <= wd_q[B_RUN];
				cksel_q[1] <= wd_q[B_CKSEL];
			end
			for (int i = 0; i < 2; i++) begin
				if (we_rl[i]) begin
					rl_q[i] <= wd_q;
				end
				if (we_cmp[i]) begin
					cmp_q[i] <= wd_q;
				end
				if (we_ps[i]) begin
					gate_q[i]  <= wd_q[B_GATE];
					src_q[i]   <= wd_q[B_SRC];
					ratio_q[i] <= wd_q[B_RATIO +: 3];
				end
			end
		end
	end

	// ==========================================================
	// prescalers
	logic [1:0] pre_tick;

	for (genvar g = 0; g < 2; g++) begin : g_presc
		logic        src_tick;
		logic [11:0] div_m1;
		logic [11:0] pre_cnt_q;
		assign src_tick = src_q[g] ? slow_osc_tick : fast_osc_tick;
		assign div_m1   = presc_div_m1(src_q[g], ratio_q[g]);
		assign pre_tick[g] = gate_q[g] && src_tick &&
		                     pre_cnt_q == div_m1;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pre_cnt_q <= 12'h000;
			end else if (pre_tick[g]) begin
				pre_cnt_q <= 12'h000;
			end else if (gate_q[g] && src_tick) begin
				pre_cnt_q <= 12'(pre_cnt_q + 12'h001);
			end
		end
	end

	// ==========================================================
	// external event input
	logic ext_lvl;
	logic ext_tick;

	assign ext_lvl  = flt_en_q ? flt_q : ext_s2_q;
	assign ext_tick = ext_prev_q && !ext_lvl;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_q   <= 1'b1;
			ext_s2_q   <= 1'b1;
			flt_q      <= 1'b1;
			flt_cnt_q  <= 4'h0;
			ext_prev_q <= 1'b1;
		end else begin
			ext_s1_q   <= external_count_clock;
			ext_s2_q   <= ext_s1_q;
			ext_prev_q <= ext_lvl;
			if (ext_s2_q == flt_q) begin
				flt_cnt_q <= 4'h0;
			end else if (slow_osc_tick) begin
				if (flt_cnt_q == FLT_LAST) begin
					flt_q     <= ext_s2_q;
					flt_cnt_q <= 4'h0;
				end else begin
					flt_cnt_q <= 4'(flt_cnt_q + 4'h1);
				end
			end
		end
	end

	// ==========================================================
	// counter clocking and cascade
	logic [1:0] match_e;
	logic [1:0] uf_e;
	logic [1:0] oe_e;

	assign ch_l.tick = run_q[0] &&
	                   (cksel_q[0] ? ext_tick : pre_tick[0]);
	assign ch_h.tick = mode_q ? ch_l.uf :
	                   run_q[1] && (cksel_q[1] ? ext_tick : pre_tick[1]);
	assign ch_l.preset  = preset_l_q;
	assign ch_h.preset  = mode_q ? preset_l_q : preset_h_q;
	assign ch_l.reload  = rl_q[0];
	assign ch_h.reload  = rl_q[1];
	assign ch_l.compare = cmp_q[0];
	assign ch_h.compare = cmp_q[1];

	assign match_e[0] = ch_l.match;
	assign match_e[1] = mode_q ? ch_l.match && ch_h.match : ch_h.match;
	assign uf_e[0]    = ch_l.uf;
	assign uf_e[1]    = ch_h.uf;
	assign oe_e[0]    = oe_q[0] && !mode_q;
	assign oe_e[1]    = oe_q[1];

	// ==========================================================
	// outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_output_signal <= 2'h0;
			timer_underflow     <= 2'h0;
		end else begin
			timer_underflow <= uf_e;
			for (int i = 0; i < 2; i++) begin
				if (!oe_e[i] || uf_e[i]) begin
					timer_output_signal[i] <= 1'b0;
				end else if (match_e[i]) begin
					timer_output_signal[i] <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_values: assert property (
		$rose(aresetn) |-> rl_q[0] == RELOAD_RST && rl_q[1] == RELOAD_RST
		&& cmp_q[0] == CMP_RST && cmp_q[1] == CMP_RST && !mode_q)
		else $error("reset values wrong");

	a_stop_hold: assert property (
		!run_q[0] && !ch_l.preset |=> ch_l.count == $past(ch_l.count))
		else $error("stopped counter changed");

	a_cascade_clk: assert property (
		mode_q |-> ch_h.tick == ch_l.uf)
		else $error("high timer not clocked by low underflow");

	a_high_preset: assert property (
		mode_q && we_ctl_h && wd_q[B_PRESET] && !we_ctl_l |=> !ch_h.preset)
		else $error("high preset acted in 16-bit mode");

	a_gate_block: assert property (
		!cksel_q[0] && !gate_q[0] |-> !ch_l.tick)
		else $error("ungated prescaler clock reached timer");

	a_ext_select: assert property (
		cksel_q[0] && run_q[0] |-> ch_l.tick == ext_tick)
		else $error("external clock not selected");

	a_filter_width: assert property (
		flt_en_q && $past(flt_en_q) && flt_q != $past(flt_q)
		|-> $past(flt_cnt_q) == FLT_LAST && $past(slow_osc_tick))
		else $error("filter passed a short pulse");

	a_pwm_set: assert property (
		oe_e[1] && match_e[1] && !uf_e[1] |=> timer_output_signal[1])
		else $error("pwm output not set on compare match");

	c_uf16: cover property (mode_q && uf_e[1]);
	c_ext_tick: cover property (cksel_q[0] && ch_l.tick);
	c_pwm_rise: cover property (!timer_output_signal[0]
		##1 timer_output_signal[0]);

endmodule

// file: tb/osc_event_source.sv
/*
 * Far side of the timer pair: slow and fast oscillator ticks and the
 * external event line, produced only on request from the bench.
 * Assumes a free-running aclk; event line idles high like a pulled-up pin.
 */
`timescale 1ns/1ps
module osc_event_source (
	input  wire logic aclk,
	output logic      slow_osc_tick,
	output logic      fast_osc_tick,
	output logic      external_count_clock
);
	initial begin
		slow_osc_tick        <= 1'b0;
		fast_osc_tick        <= 1'b0;
		external_count_clock <= 1'b1;
	end

	// n one-cycle ticks, one every per cycles
	task automatic ticks(input bit slow, input int n, input int per);
		repeat (n) begin
			@(posedge aclk);
			if (slow) begin
				slow_osc_tick <= 1'b1;
			end else begin
				fast_osc_tick <= 1'b1;
			end
			@(posedge aclk);
			slow_osc_tick <= 1'b0;
			fast_osc_tick <= 1'b0;
			repeat (per - 2) @(posedge aclk);
		end
	endtask

	// low then high, each for w slow periods
	task automatic ext_pulse(input int w);
		@(posedge aclk);
		external_count_clock <= 1'b0;
		ticks(1'b1, w, 4);
		@(posedge aclk);
		external_count_clock <= 1'b1;
		ticks(1'b1, w, 4);
	endtask
endmodule

// file: tb/timer_pair_bench.sv
/*
 * Self-checking bench of timer_pair: AXI4-Lite master tasks note
 * expected answers in queues, a monitor compares them.
 * Assumes osc_event_source as the far side.
 */
`timescale 1ns/1ps
module timer_pair_bench;
	import ptimer_pkg::*;
	typedef struct {
		logic [15:0] idx;
		logic [31:0] d;
		logic [1:0]  r;
		bit          chk;
	} note_s;
	logic              aclk, aresetn, awvalid, wvalid, bready;
	logic              arvalid, rready, awready, wready, bvalid;
	logic              arready, rvalid, slow_t, fast_t, ext_clk;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, tout, uf;
	logic [7:0]        rd_v;
	note_s             rq[$];
	logic [1:0]        bq[$];
	int                miscompares, total_checks, uf0_cnt, seed, rl;
	int                uf1_cnt;
	int                fdiv[7] = '{2, 8, 32, 64, 256, 1024, 4096};

	timer_pair dut (.aclk(aclk), .aresetn(aresetn),
		.slow_osc_tick(slow_t), .fast_osc_tick(fast_t),
		.external_count_clock(ext_clk), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .timer_output_signal(tout),
		.timer_underflow(uf));
	osc_event_source src (.aclk(aclk), .slow_osc_tick(slow_t),
		.fast_osc_tick(fast_t), .external_count_clock(ext_clk));

	initial aclk = 1'b0;
	always #10 aclk = ~aclk;

	task automatic cmp(input string n, input logic [31:0] e,
	                   input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim();
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==========================================================
	// monitor
	always @(posedge aclk) begin
		note_s n;
		if (uf[0] === 1'b1) begin
			uf0_cnt++;
		end
		if (uf[1] === 1'b1) begin
			uf1_cnt++;
		end
		if (bvalid && bready) begin
			cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
		end
		if (rvalid && rready) begin
			n = rq.pop_front();
			if (n.chk) begin
				cmp($sformatf("rdata %h", n.idx), n.d, rdata);
				cmp("rresp", {30'h0, n.r}, {30'h0, rresp});
			end
		end
	end

	// ==========================================================
	// bus master
	task automatic axw(input logic [15:0] i, input logic [7:0] d,
	                   input logic [1:0] r, input logic [3:0] s = 4'h1);
		bit a, w;
		a = 0;
		w = 0;
		@(posedge aclk);
		bq.push_back(r);
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (!a && awready) begin
				awvalid <= 1'b0;
				a = 1;
			end
			if (!w && wready) begin
				wvalid <= 1'b0;
				w = 1;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [15:0] i, input logic [7:0] e,
	                   input logic [1:0] r = RESP_OKAY, input bit c = 1);
		bit g;
		g = 0;
		@(posedge aclk);
		rq.push_back('{i, {24'h0, e}, r, c});
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (1) begin
			@(posedge aclk);
			if (g && rvalid) break;
			if (!g && arready) begin
				arvalid <= 1'b0;
				g = 1;
			end
		end
		rd_v = rdata[7:0];
		rready <= 1'b0;
	endtask

	// decrement of the low count over n source ticks
	task automatic meas(input logic [7:0] p, input bit s, input int n,
	                    input int dec);
		logic [7:0] v;
		axw(IDX_PRESC_L, p, RESP_OKAY);
		axr(IDX_COUNT_L, 8'h00, RESP_OKAY, 0);
		v = rd_v;
		src.ticks(s, n, 2);
		axr(IDX_COUNT_L, 8'(v - 8'(dec)));
	endtask

	initial begin
		repeat (100000) @(posedge aclk);
		miscompares++;
		end_sim();
	end

	// ==========================================================
	// scenarios
	initial begin
		seed = 73;
		uf0_cnt = 0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		awaddr <= '0;
		araddr <= '0;
		wdata <= 32'h0;
		wstrb <= 4'h0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(IDX_CTRL_L, 8'h00);
		axr(IDX_CTRL_H, 8'h00);
		axr(IDX_RELOAD_L, 8'hFF);
		axr(IDX_CMP_H, 8'h00);
		axr(IDX_COUNT_H, 8'hFF);
		axr(16'hFF3A, 8'h00, RESP_SLVERR);
		axw(16'hFF3A, 8'h55, RESP_SLVERR);
		axw(IDX_RELOAD_H, 8'h12, RESP_OKAY, 4'h0);
		axr(IDX_RELOAD_H, 8'hFF);
		axw(IDX_CTRL_L, 8'h7E, RESP_OKAY);
		axr(IDX_CTRL_L, 8'h5C);
		axw(IDX_CTRL_H, 8'hFF, RESP_OKAY);
		axr(IDX_CTRL_H, 8'h1D);
		axw(IDX_CTRL_H, 8'h00, RESP_OKAY);
		axw(IDX_CTRL_L, 8'h04, RESP_OKAY);
		meas(8'h10, 0, 4, 4);
		meas(8'h08, 1, 5, 0);
		meas(8'h18, 0, 5, 0);
		for (int c = 0; c < 8; c++) begin
			meas(8'(8'h18 | c), 1, 4 << c, 4);
		end
		for (int c = 1; c < 8; c++) begin
			meas(8'(8'h10 | c), 0, 4 * fdiv[c - 1], 4);
		end
		axw(IDX_PRESC_L, 8'h00, RESP_OKAY);
		rl = 1 + ($random(seed) & 7);
		axw(IDX_RELOAD_L, 8'(rl), RESP_OKAY);
		axw(IDX_CTRL_L, 8'h07, RESP_OKAY);
		uf0_cnt = 0;
		repeat (rl + 2) src.ext_pulse(2);
		axr(IDX_COUNT_L, 8'(rl - 1));
		cmp("underflow0", 32'd1, 32'(uf0_cnt));
		axr(IDX_COUNT_H, 8'hFF);
		axw(IDX_CTRL_L, 8'h01, RESP_OKAY);
		repeat (2) src.ext_pulse(2);
		axr(IDX_COUNT_L, 8'(rl - 1));
		axw(IDX_CTRL_L, 8'h47, RESP_OKAY);
		src.ext_pulse(8);
		src.ext_pulse(40);
		axr(IDX_COUNT_L, 8'(rl - 1));
		axw(IDX_CMP_L, 8'(rl - 1), RESP_OKAY);
		axw(IDX_CTRL_L, 8'h0D, RESP_OKAY);
		axr(IDX_CMP_L, 8'(rl - 1));
		cmp("pwm0 on match", 32'd1, {31'h0, tout[0]});
		uf0_cnt = 0;
		repeat (rl) src.ext_pulse(2);
		cmp("pwm0 after uf", 32'd0, {31'h0, tout[0]});
		cmp("underflow0 again", 32'd1, 32'(uf0_cnt));
		src.ext_pulse(2);
		cmp("pwm0 rematch", 32'd1, {31'h0, tout[0]});
		axw(IDX_RELOAD_L, 8'h02, RESP_OKAY);
		axw(IDX_RELOAD_H, 8'h05, RESP_OKAY);
		axw(IDX_CTRL_H, 8'h05, RESP_OKAY);
		axw(IDX_CTRL_L, 8'h8F, RESP_OKAY);
		axr(IDX_CTRL_L, 8'h85);
		axr(IDX_CTRL_H, 8'h00);
		axr(IDX_COUNT_H, 8'h05);
		repeat (3) src.ext_pulse(2);
		axr(IDX_COUNT_L, 8'h02);
		axr(IDX_COUNT_H, 8'h04);
		cmp("pwm0 in 16-bit", 32'd0, {31'h0, tout[0]});
		axw(IDX_CTRL_H, 8'h02, RESP_OKAY);
		axr(IDX_COUNT_H, 8'h04);
		axw(IDX_RELOAD_H, 8'h00, RESP_OKAY);
		axw(IDX_RELOAD_L, 8'h01, RESP_OKAY);
		axw(IDX_CTRL_L, 8'h8F, RESP_OKAY);
		uf1_cnt = 0;
		repeat (2) src.ext_pulse(2);
		cmp("underflow1", 32'd1, 32'(uf1_cnt));
		axr(IDX_COUNT_H, 8'h00);
		axr(IDX_COUNT_L, 8'h01);
		end_sim();
	end
endmodule
